// >>> logic/pci_ctl_pkg.sv
// shared constants and types for the bus control handshake block
package pci_ctl_pkg;

   // command register view
   localparam logic [7:0] CMD_REG_OFFSET = 8'h04;
   localparam int CMD_PERR_EN_BIT = 6;
   localparam int CMD_SERR_EN_BIT = 8;

   // bus command codes, address phase
   localparam logic [2:0] CMD_CFG_HI = 3'h5;

   // initiator waits this many clocks after frame start for a claim
   localparam logic [3:0] DEVSEL_TIMEOUT_CLKS = 4'h5;

   // reset values
   localparam logic [7:0] LEFT_RST = 8'h00;
   localparam logic [3:0] TMO_RST = 4'h0;

   // control lines as sampled, active high
   typedef struct packed {
      logic frame;
      logic irdy;
      logic trdy;
      logic devsel;
      logic stop;
   } ctl_t;

   // one driven control pin: level and enable (enable low drives)
   typedef struct packed {
      logic lvl;
      logic oe_n;
   } drv_t;

   typedef enum logic [1:0] {I_IDLE, I_ADDR, I_DATA, I_TURN} init_st_t;
   typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN} tgt_st_t;

endpackage : pci_ctl_pkg

// >>> logic/pci_ctl.sv
// bus control handshake: claim, framing, ready handshake, arbitration, parity errors
// Contract
// - as target, assert the select line to claim a cycle addressed here
// - as initiator, watch select; end with master abort if nobody claims
// - the initiator drives frame; transfers run while frame is asserted
// - frame released means the current data phase is the last one
// - grant may come unrequested through parking; handle it
// - answer configuration cycles only when the chip select input is high
// - a data phase completes on an edge with both ready lines asserted
// - drive parity error on mismatch only when command bit 6 is set
// - pulse system error when command bit 8 is set, even when not target
// - also pulse system error on card side address parity error
// - assert request to the arbiter whenever an initiator cycle is needed
// - target may assert stop; the initiator ends the transaction then
// - even parity over data and command lines, driven one clock later
`timescale 1ns/1ns
module pci_ctl #(
   parameter int LEN_W = 8
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   // arbitration
   output logic REQ_N,
   input wire logic GNT_N,
   input wire logic IDSEL,
   // shared control lines
   input wire logic FRAME_N_I,
   output logic FRAME_N_O,
   output logic FRAME_N_OE_N,
   input wire logic IRDY_N_I,
   output logic IRDY_N_O,
   output logic IRDY_N_OE_N,
   input wire logic TRDY_N_I,
   output logic TRDY_N_O,
   output logic TRDY_N_OE_N,
   input wire logic DEVSEL_N_I,
   output logic DEVSEL_N_O,
   output logic DEVSEL_N_OE_N,
   input wire logic STOP_N_I,
   output logic STOP_N_O,
   output logic STOP_N_OE_N,
   // parity and errors
   input wire logic [31:0] AD_I,
   input wire logic [3:0] CBE_N_I,
   input wire logic AD_OE_N,
   input wire logic PAR_I,
   output logic PAR_O,
   output logic PAR_OE_N,
   input wire logic PERR_N_I,
   output logic PERR_N_O,
   output logic PERR_N_OE_N,
   output logic SERR_N_O,
   output logic SERR_N_OE_N,
   input wire logic [15:0] CMD_REG,
   input wire logic CB_ADDR_PERR,
   // initiator user side
   input wire logic INIT_START,
   input wire logic [LEN_W-1:0] INIT_LEN,
   output logic INIT_BUSY,
   output logic INIT_XFER,
   output logic INIT_DONE,
   output logic INIT_ABORT,
   output logic PARKED,
   // target user side
   input wire logic TGT_HIT,
   input wire logic TGT_READY,
   input wire logic TGT_DISC,
   output logic TGT_SEL,
   output logic TGT_XFER,
   output logic PERR_SEEN
);

   pci_ctl_pkg::ctl_t bus;
   pci_ctl_pkg::init_st_t ist_r;
   pci_ctl_pkg::tgt_st_t tst_r;
   pci_ctl_pkg::drv_t frame_r, irdy_r, trdy_r, devsel_r, stop_r;
   logic pend_r;
   logic [LEN_W-1:0] left_r;
   logic last_r;
   logic [3:0] tmo_r;
   logic claimed_r;
   logic frame_prev_r;
   logic tgt_wr_r;
   logic par_calc_r;
   logic addr_chk_r;
   logic data_chk_r;
   logic [1:0] perr_seq_r;
   logic addr_phase;
   logic is_cfg;
   logic tgt_hit_now;
   logic phase_done;
   logic bus_idle;

   // pins are synchronous to this clock; only the active sense is flipped
   assign bus = '{frame: ~FRAME_N_I, irdy: ~IRDY_N_I, trdy: ~TRDY_N_I,
                  devsel: ~DEVSEL_N_I, stop: ~STOP_N_I};
   assign bus_idle = ~bus.frame & ~bus.irdy;
   assign phase_done = bus.irdy & bus.trdy;
   assign addr_phase = bus.frame & ~frame_prev_r & ~bus.irdy;
   // command codes are the raw line levels, not the inverted byte enables
   assign is_cfg = CBE_N_I[3:1] == pci_ctl_pkg::CMD_CFG_HI;
   // configuration cycles need the chip select, others the address decode
   assign tgt_hit_now = is_cfg ? IDSEL : TGT_HIT;

   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         frame_prev_r <= 1'b0;
      end
      else
      begin
         frame_prev_r <= bus.frame;
      end
   end

   // pending request and the request line
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         pend_r <= 1'b0;
         REQ_N <= 1'b1;
      end
      else
      begin
         if (ist_r == pci_ctl_pkg::I_ADDR)
         begin
            pend_r <= 1'b0;
         end
         else if (INIT_START && ist_r == pci_ctl_pkg::I_IDLE)
         begin
            pend_r <= 1'b1;
         end
         // request held until the address phase ends
         REQ_N <= ~((pend_r | INIT_START) && ist_r == pci_ctl_pkg::I_IDLE);
      end
   end

   // initiator sequence
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         ist_r <= pci_ctl_pkg::I_IDLE;
         frame_r <= '{lvl: 1'b1, oe_n: 1'b1};
         irdy_r <= '{lvl: 1'b1, oe_n: 1'b1};
         left_r <= LEN_W'(pci_ctl_pkg::LEFT_RST);
         last_r <= 1'b0;
         tmo_r <= pci_ctl_pkg::TMO_RST;
         claimed_r <= 1'b0;
         INIT_XFER <= 1'b0;
         INIT_DONE <= 1'b0;
         INIT_ABORT <= 1'b0;
         PARKED <= 1'b0;
      end
      else
      begin
         INIT_XFER <= 1'b0;
         INIT_DONE <= 1'b0;
         INIT_ABORT <= 1'b0;
         // grant with nothing pending: bus parked here, datapath keeps it driven
         PARKED <= ~GNT_N & ~pend_r & bus_idle & ist_r == pci_ctl_pkg::I_IDLE;
         case (ist_r)
            pci_ctl_pkg::I_IDLE:
            begin
               frame_r.oe_n <= 1'b1;
               irdy_r.oe_n <= 1'b1;
               // grant only counts once the running transaction is over
               if (pend_r && !GNT_N && bus_idle && tst_r == pci_ctl_pkg::T_IDLE)
               begin
                  ist_r <= pci_ctl_pkg::I_ADDR;
                  frame_r <= '{lvl: 1'b0, oe_n: 1'b0};
                  irdy_r <= '{lvl: 1'b1, oe_n: 1'b0};
                  left_r <= INIT_LEN;
                  last_r <= 1'b0;
                  tmo_r <= 4'h1;
                  claimed_r <= 1'b0;
               end
            end
            pci_ctl_pkg::I_ADDR:
            begin
               ist_r <= pci_ctl_pkg::I_DATA;
               irdy_r.lvl <= 1'b0;
               tmo_r <= tmo_r + 4'h1;
               // single phase: frame drops with the first data phase
               if (left_r <= LEN_W'(1))
               begin
                  frame_r.lvl <= 1'b1;
                  last_r <= 1'b1;
               end
            end
            pci_ctl_pkg::I_DATA:
            begin
               if (tmo_r != 4'hF)
               begin
                  tmo_r <= tmo_r + 4'h1;
               end
               if (bus.devsel)
               begin
                  claimed_r <= 1'b1;
               end
               if (!claimed_r && !bus.devsel && tmo_r >= pci_ctl_pkg::DEVSEL_TIMEOUT_CLKS)
               begin
                  // nobody claimed: master abort
                  ist_r <= pci_ctl_pkg::I_TURN;
                  frame_r.lvl <= 1'b1;
                  irdy_r.lvl <= 1'b1;
                  INIT_ABORT <= 1'b1;
               end
               else if (last_r && (phase_done || (bus.irdy && bus.stop)))
               begin
                  ist_r <= pci_ctl_pkg::I_TURN;
                  irdy_r.lvl <= 1'b1;
                  INIT_XFER <= phase_done;
                  INIT_DONE <= 1'b1;
               end
               else if (bus.stop)
               begin
                  // target wants out: make the current phase the last
                  frame_r.lvl <= 1'b1;
                  last_r <= 1'b1;
                  if (phase_done)
                  begin
                     left_r <= left_r - LEN_W'(1);
                     INIT_XFER <= 1'b1;
                  end
               end
               else if (phase_done)
               begin
                  left_r <= left_r - LEN_W'(1);
                  INIT_XFER <= 1'b1;
                  if (left_r == LEN_W'(2))
                  begin
                     frame_r.lvl <= 1'b1;
                     last_r <= 1'b1;
                  end
               end
            end
            pci_ctl_pkg::I_TURN:
            begin
               // lines driven high one clock before release
               ist_r <= pci_ctl_pkg::I_IDLE;
               frame_r <= '{lvl: 1'b1, oe_n: 1'b1};
               irdy_r <= '{lvl: 1'b1, oe_n: 1'b1};
            end
            default:
            begin
               ist_r <= pci_ctl_pkg::I_IDLE;
            end
         endcase
      end
   end

   // target sequence
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         tst_r <= pci_ctl_pkg::T_IDLE;
         devsel_r <= '{lvl: 1'b1, oe_n: 1'b1};
         trdy_r <= '{lvl: 1'b1, oe_n: 1'b1};
         stop_r <= '{lvl: 1'b1, oe_n: 1'b1};
         tgt_wr_r <= 1'b0;
         TGT_XFER <= 1'b0;
      end
      else
      begin
         TGT_XFER <= 1'b0;
         case (tst_r)
            pci_ctl_pkg::T_IDLE:
            begin
               devsel_r.oe_n <= 1'b1;
               trdy_r.oe_n <= 1'b1;
               stop_r.oe_n <= 1'b1;
               // never claim our own initiator cycle
               if (addr_phase && tgt_hit_now && ist_r == pci_ctl_pkg::I_IDLE)
               begin
                  tst_r <= pci_ctl_pkg::T_DATA;
                  devsel_r <= '{lvl: 1'b0, oe_n: 1'b0};
                  trdy_r <= '{lvl: ~TGT_READY, oe_n: 1'b0};
                  stop_r <= '{lvl: ~TGT_DISC, oe_n: 1'b0};
                  tgt_wr_r <= CBE_N_I[0];
               end
            end
            pci_ctl_pkg::T_DATA:
            begin
               if (bus.irdy && (bus.trdy || bus.stop) && !bus.frame)
               begin
                  tst_r <= pci_ctl_pkg::T_TURN;
                  devsel_r.lvl <= 1'b1;
                  trdy_r.lvl <= 1'b1;
                  stop_r.lvl <= 1'b1;
                  TGT_XFER <= phase_done;
               end
               else
               begin
                  TGT_XFER <= phase_done;
                  trdy_r.lvl <= ~TGT_READY;
                  // stop stays up until the initiator ends the frame
                  stop_r.lvl <= stop_r.lvl & ~TGT_DISC;
               end
            end
            pci_ctl_pkg::T_TURN:
            begin
               tst_r <= pci_ctl_pkg::T_IDLE;
               devsel_r.oe_n <= 1'b1;
               trdy_r.oe_n <= 1'b1;
               stop_r.oe_n <= 1'b1;
            end
            default:
            begin
               tst_r <= pci_ctl_pkg::T_IDLE;
            end
         endcase
      end
   end

   // parity: computed every clock, checked or driven one clock later
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         par_calc_r <= 1'b0;
         PAR_O <= 1'b0;
         PAR_OE_N <= 1'b1;
         addr_chk_r <= 1'b0;
         data_chk_r <= 1'b0;
      end
      else
      begin
         par_calc_r <= ^{AD_I, CBE_N_I};
         PAR_O <= ^{AD_I, CBE_N_I};
         PAR_OE_N <= AD_OE_N;
         addr_chk_r <= addr_phase;
         data_chk_r <= tst_r == pci_ctl_pkg::T_DATA && tgt_wr_r && phase_done;
      end
   end

   // error signalling
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         perr_seq_r <= 2'h0;
         PERR_N_O <= 1'b1;
         PERR_N_OE_N <= 1'b1;
         SERR_N_O <= 1'b0;
         SERR_N_OE_N <= 1'b1;
         PERR_SEEN <= 1'b0;
      end
      else
      begin
         SERR_N_O <= 1'b0;
         // address parity on any cycle, ours or not, plus the card side
         SERR_N_OE_N <= ~(CMD_REG[pci_ctl_pkg::CMD_SERR_EN_BIT] &&
            ((addr_chk_r && PAR_I != par_calc_r) || CB_ADDR_PERR));
         if (data_chk_r && PAR_I != par_calc_r && CMD_REG[pci_ctl_pkg::CMD_PERR_EN_BIT])
         begin
            perr_seq_r <= 2'h2;
         end
         else if (perr_seq_r != 2'h0)
         begin
            perr_seq_r <= perr_seq_r - 2'h1;
         end
         // low one clock, then high one clock before release
         PERR_N_O <= ~(data_chk_r && PAR_I != par_calc_r &&
            CMD_REG[pci_ctl_pkg::CMD_PERR_EN_BIT]);
         PERR_N_OE_N <= ~((data_chk_r && PAR_I != par_calc_r &&
            CMD_REG[pci_ctl_pkg::CMD_PERR_EN_BIT]) || perr_seq_r == 2'h2);
         PERR_SEEN <= ~PERR_N_I;
      end
   end

   // pin and status register images
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         INIT_BUSY <= 1'b0;
         TGT_SEL <= 1'b0;
      end
      else
      begin
         INIT_BUSY <= pend_r | (ist_r != pci_ctl_pkg::I_IDLE);
         TGT_SEL <= tst_r == pci_ctl_pkg::T_DATA;
      end
   end

   assign FRAME_N_O = frame_r.lvl;
   assign FRAME_N_OE_N = frame_r.oe_n;
   assign IRDY_N_O = irdy_r.lvl;
   assign IRDY_N_OE_N = irdy_r.oe_n;
   assign TRDY_N_O = trdy_r.lvl;
   assign TRDY_N_OE_N = trdy_r.oe_n;
   assign DEVSEL_N_O = devsel_r.lvl;
   assign DEVSEL_N_OE_N = devsel_r.oe_n;
   assign STOP_N_O = stop_r.lvl;
   assign STOP_N_OE_N = stop_r.oe_n;

endmodule : pci_ctl

// >>> verif/pci_ctl_monitor.sv
// checker for the bus control handshake ports
`timescale 1ns/1ns
module pci_ctl_monitor (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   // bus lines
   input wire logic REQ_N,
   input wire logic IDSEL,
   input wire logic FRAME_N_I,
   input wire logic IRDY_N_I,
   input wire logic TRDY_N_I,
   input wire logic DEVSEL_N_I,
   input wire logic DEVSEL_N_OE_N,
   input wire logic [31:0] AD_I,
   input wire logic [3:0] CBE_N_I,
   input wire logic PAR_O,
   input wire logic PAR_OE_N,
   input wire logic PERR_N_O,
   input wire logic PERR_N_OE_N,
   input wire logic SERR_N_O,
   input wire logic SERR_N_OE_N,
   input wire logic [15:0] CMD_REG,
   input wire logic CB_ADDR_PERR,
   // user side
   input wire logic INIT_START,
   input wire logic INIT_BUSY,
   input wire logic INIT_DONE,
   input wire logic INIT_ABORT,
   input wire logic TGT_HIT,
   input wire logic TGT_XFER
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SYS_RST);

   property p_claim;
      $fell(DEVSEL_N_OE_N) |-> !$past(FRAME_N_I) &&
         (($past(CBE_N_I[3:1]) == pci_ctl_pkg::CMD_CFG_HI) ? $past(IDSEL) : $past(TGT_HIT));
   endproperty
   a_claim: assert property (p_claim) else $error("claim without address hit");
   property p_abort;
      INIT_ABORT |-> $past(DEVSEL_N_I) && $past(DEVSEL_N_I, 2) && $past(DEVSEL_N_I, 3);
   endproperty
   a_abort: assert property (p_abort) else $error("abort although claimed");
   property p_done;
      INIT_DONE |-> $past(FRAME_N_I) && !$past(IRDY_N_I) && !$past(TRDY_N_I);
   endproperty
   a_done: assert property (p_done) else $error("done without final phase");
   property p_txfer;
      TGT_XFER |-> !$past(IRDY_N_I) && !$past(TRDY_N_I);
   endproperty
   a_txfer: assert property (p_txfer) else $error("transfer without both ready");
   property p_perr;
      $fell(PERR_N_OE_N) |-> !PERR_N_O && $past(CMD_REG[pci_ctl_pkg::CMD_PERR_EN_BIT]);
   endproperty
   a_perr: assert property (p_perr) else $error("parity error while disabled");
   property p_serr;
      !SERR_N_OE_N |-> !SERR_N_O && $past(CMD_REG[pci_ctl_pkg::CMD_SERR_EN_BIT]) ##1 SERR_N_OE_N;
   endproperty
   a_serr: assert property (p_serr) else $error("system error pulse wrong");
   property p_cbserr;
      CB_ADDR_PERR && CMD_REG[pci_ctl_pkg::CMD_SERR_EN_BIT] |=> !SERR_N_OE_N;
   endproperty
   a_cbserr: assert property (p_cbserr) else $error("card side error not reported");
   property p_req;
      INIT_START && !INIT_BUSY |-> ##[1:2] !REQ_N;
   endproperty
   a_req: assert property (p_req) else $error("request not raised");
   property p_par;
      !PAR_OE_N |-> PAR_O == ^{$past(AD_I), $past(CBE_N_I)};
   endproperty
   a_par: assert property (p_par) else $error("parity output wrong");

   c_done: cover property (INIT_DONE);
   c_abort: cover property (INIT_ABORT);
   c_xfer: cover property (TGT_XFER);
endmodule : pci_ctl_monitor

// >>> verif/pci_far_model.sv
// far side model: arbiter with parking and a claiming target
`timescale 1ns/1ns
module pci_far_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // 0 fast, 1 wait states, 2 no claim, 3 park
   input wire logic [1:0] mode,
   // bus
   input wire logic req_n,
   input wire logic frame_n,
   input wire logic irdy_n,
   input wire logic bus_trdy_n,
   output logic gnt_n,
   output logic devsel_n,
   output logic trdy_n
);
   logic act_r, frame_q_r, tog_r;

   always @(posedge clk)
   begin
      if (rst)
      begin
         gnt_n <= 1'b1;
         act_r <= 1'b0;
         frame_q_r <= 1'b1;
         tog_r <= 1'b0;
      end
      else
      begin
         frame_q_r <= frame_n;
         tog_r <= !tog_r;
         // parking grants with no request pending
         gnt_n <= req_n && mode != 2'h3;
         if (!frame_n && frame_q_r && mode != 2'h2)
            act_r <= 1'b1;
         else if (frame_n && !irdy_n && !bus_trdy_n)
            act_r <= 1'b0;
      end
   end

   // released lines fall back to the pull-up level
   assign devsel_n = !act_r;
   assign trdy_n = !(act_r && (mode != 2'h1 || tog_r));
endmodule : pci_far_model

// >>> verif/tb.sv
// self-checking bench for the bus control handshake
`timescale 1ns/1ns
module tb;
   logic CLK_SYS = 1'b0;
   logic SYS_RST = 1'b1;
   logic GNT_N, FRAME_N_I, IRDY_N_I, TRDY_N_I, DEVSEL_N_I, STOP_N_I, PERR_N_I;
   logic IDSEL = 1'b0, AD_OE_N = 1'b1, PAR_I = 1'b0, CB_ADDR_PERR = 1'b0, flip = 1'b0;
   logic [31:0] AD_I = 32'h0;
   logic [3:0] CBE_N_I = 4'hF;
   logic [15:0] CMD_REG = 16'h0000;
   logic INIT_START = 1'b0, TGT_HIT = 1'b0, TGT_READY = 1'b1, TGT_DISC = 1'b0;
   logic [7:0] INIT_LEN = 8'h01;
   logic REQ_N, FRAME_N_O, FRAME_N_OE_N, IRDY_N_O, IRDY_N_OE_N, TRDY_N_O, TRDY_N_OE_N;
   logic DEVSEL_N_O, DEVSEL_N_OE_N, STOP_N_O, STOP_N_OE_N, PAR_O, PAR_OE_N, PERR_N_O;
   logic PERR_N_OE_N, SERR_N_O, SERR_N_OE_N, INIT_BUSY, INIT_XFER, INIT_DONE, INIT_ABORT;
   logic PARKED, TGT_SEL, TGT_XFER, PERR_SEEN, frame_x = 1'b1, irdy_x = 1'b1, m_dev, m_trdy;
   logic [1:0] mode = 2'h2;
   int failures = 0, tests_run = 0, seed = 63;
   int exq[$];

   always #20 CLK_SYS = ~CLK_SYS;

   // pulled-up shared lines
   assign FRAME_N_I = FRAME_N_OE_N ? frame_x : FRAME_N_O;
   assign IRDY_N_I = IRDY_N_OE_N ? irdy_x : IRDY_N_O;
   assign TRDY_N_I = (TRDY_N_OE_N | TRDY_N_O) & m_trdy;
   assign DEVSEL_N_I = (DEVSEL_N_OE_N | DEVSEL_N_O) & m_dev;
   assign STOP_N_I = STOP_N_OE_N | STOP_N_O;
   assign PERR_N_I = PERR_N_OE_N | PERR_N_O;

   pci_ctl i_dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .REQ_N(REQ_N), .GNT_N(GNT_N),
      .IDSEL(IDSEL), .FRAME_N_I(FRAME_N_I), .FRAME_N_O(FRAME_N_O),
      .FRAME_N_OE_N(FRAME_N_OE_N), .IRDY_N_I(IRDY_N_I), .IRDY_N_O(IRDY_N_O),
      .IRDY_N_OE_N(IRDY_N_OE_N), .TRDY_N_I(TRDY_N_I), .TRDY_N_O(TRDY_N_O),
      .TRDY_N_OE_N(TRDY_N_OE_N), .DEVSEL_N_I(DEVSEL_N_I), .DEVSEL_N_O(DEVSEL_N_O),
      .DEVSEL_N_OE_N(DEVSEL_N_OE_N), .STOP_N_I(STOP_N_I), .STOP_N_O(STOP_N_O),
      .STOP_N_OE_N(STOP_N_OE_N), .AD_I(AD_I), .CBE_N_I(CBE_N_I), .AD_OE_N(AD_OE_N),
      .PAR_I(PAR_I), .PAR_O(PAR_O), .PAR_OE_N(PAR_OE_N), .PERR_N_I(PERR_N_I),
      .PERR_N_O(PERR_N_O), .PERR_N_OE_N(PERR_N_OE_N), .SERR_N_O(SERR_N_O),
      .SERR_N_OE_N(SERR_N_OE_N), .CMD_REG(CMD_REG), .CB_ADDR_PERR(CB_ADDR_PERR),
      .INIT_START(INIT_START), .INIT_LEN(INIT_LEN), .INIT_BUSY(INIT_BUSY),
      .INIT_XFER(INIT_XFER), .INIT_DONE(INIT_DONE), .INIT_ABORT(INIT_ABORT),
      .PARKED(PARKED), .TGT_HIT(TGT_HIT), .TGT_READY(TGT_READY), .TGT_DISC(TGT_DISC),
      .TGT_SEL(TGT_SEL), .TGT_XFER(TGT_XFER), .PERR_SEEN(PERR_SEEN));

   pci_far_model i_far (.clk(CLK_SYS), .rst(SYS_RST), .mode(mode), .req_n(REQ_N),
      .frame_n(FRAME_N_I), .irdy_n(IRDY_N_I), .bus_trdy_n(TRDY_N_I), .gnt_n(GNT_N),
      .devsel_n(m_dev), .trdy_n(m_trdy));

   // parity follows the previous clock's lines, as a bus initiator drives it
   always @(negedge CLK_SYS)
   begin
      AD_I <= $random(seed);
      PAR_I <= ^{AD_I, CBE_N_I} ^ flip;
      AD_OE_N <= FRAME_N_OE_N & IRDY_N_OE_N;
      TGT_READY <= $random(seed);
   end

   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: expected %0h got %0h", $time, exp, got);
      end
   endtask : chk

   task automatic test_done;
      $display("%0d checks, %0d mismatches", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done

   // results: 1 done, 2 abort, 3 target transfer, 4 system error, 5 parity error
   // sampled mid-cycle, where every one-clock pulse has settled
   always @(negedge CLK_SYS)
   begin
      logic [7:0] res;
      res = INIT_DONE ? 8'h01 : INIT_ABORT ? 8'h02 : TGT_XFER ? 8'h03 :
         !SERR_N_OE_N ? 8'h04 : (!PERR_N_OE_N && !PERR_N_O) ? 8'h05 : 8'h00;
      if (!SYS_RST && res !== 8'h00)
         chk(exq.size() > 0 ? 8'(exq.pop_front()) : 8'h00, res);
   end

   task automatic init_xfer(input logic [7:0] len, input logic [1:0] md, input int exp);
      int i;
      int n = 0;
      @(negedge CLK_SYS);
      mode <= md;
      exq.push_back(exp);
      INIT_LEN <= len;
      INIT_START <= 1'b1;
      @(negedge CLK_SYS);
      INIT_START <= 1'b0;
      // busy is registered: let it rise before waiting for its fall
      @(negedge CLK_SYS);
      for (i = 0; i < 80 && INIT_BUSY !== 1'b0; i++)
      begin
         n += INIT_XFER;
         @(negedge CLK_SYS);
      end
      if (INIT_BUSY !== 1'b0)
      begin
         chk(8'h00, 8'h01);
         test_done;
      end
      chk(exp == 1 ? len : 8'h00, 8'(n));
      repeat (4) @(negedge CLK_SYS);
   endtask : init_xfer

   // another initiator runs one single-phase cycle against the block
   task automatic host_cyc(input logic [3:0] cmd, input logic sel, input logic hit,
      input logic f, input int exp);
      int i;
      @(negedge CLK_SYS);
      mode <= 2'h2;
      if (exp % 256 != 0)
         exq.push_back(exp % 256);
      // a second expected result rides in the upper byte
      if (exp > 255)
         exq.push_back(exp / 256);
      frame_x <= 1'b0;
      CBE_N_I <= cmd;
      IDSEL <= sel;
      TGT_HIT <= hit;
      flip <= f;
      @(negedge CLK_SYS);
      frame_x <= 1'b1;
      irdy_x <= 1'b0;
      IDSEL <= 1'b0;
      TGT_HIT <= 1'b0;
      for (i = 0; i < 16; i++)
      begin
         @(posedge CLK_SYS);
         if (!TRDY_N_I && !DEVSEL_N_I)
            break;
      end
      if (i == 16 && exp % 256 == 3)
      begin
         chk(8'h03, 8'h00);
         test_done;
      end
      @(negedge CLK_SYS);
      irdy_x <= 1'b1;
      flip <= 1'b0;
      repeat (6) @(negedge CLK_SYS);
   endtask : host_cyc

   task automatic cb_err(input int exp);
      @(negedge CLK_SYS);
      if (exp != 0)
         exq.push_back(exp);
      CB_ADDR_PERR <= 1'b1;
      @(negedge CLK_SYS);
      CB_ADDR_PERR <= 1'b0;
      repeat (4) @(negedge CLK_SYS);
   endtask : cb_err

   initial
   begin
      int k;
      repeat (16) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      SYS_RST <= 1'b0;
      for (k = 0; k < 6; k++)
         init_xfer(8'(1 + {$random(seed)} % 4), 2'(k % 2), 1);
      init_xfer(8'h02, 2'h2, 2);
      $display("test initiator done");
      host_cyc(4'h7, 1'b0, 1'b1, 1'b0, 3);
      host_cyc(4'hA, 1'b1, 1'b0, 1'b0, 3);
      host_cyc(4'hB, 1'b0, 1'b1, 1'b0, 0);
      $display("test target done");
      CMD_REG <= 16'h0100;
      host_cyc(4'h6, 1'b0, 1'b0, 1'b1, 4);
      cb_err(4);
      CMD_REG <= 16'h0040;
      host_cyc(4'h7, 1'b0, 1'b1, 1'b1, 32'h0503);
      cb_err(0);
      $display("test errors done");
      mode <= 2'h3;
      repeat (5) @(negedge CLK_SYS);
      chk(8'h01, 8'(PARKED));
      init_xfer(8'h03, 2'h3, 1);
      $display("test parking done");
      chk(8'h00, 8'(exq.size()));
      test_done;
   end
endmodule : tb

bind pci_ctl pci_ctl_monitor i_mon (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .REQ_N(REQ_N),
   .IDSEL(IDSEL), .FRAME_N_I(FRAME_N_I), .IRDY_N_I(IRDY_N_I), .TRDY_N_I(TRDY_N_I),
   .DEVSEL_N_I(DEVSEL_N_I), .DEVSEL_N_OE_N(DEVSEL_N_OE_N), .AD_I(AD_I),
   .CBE_N_I(CBE_N_I), .PAR_O(PAR_O), .PAR_OE_N(PAR_OE_N), .PERR_N_O(PERR_N_O),
   .PERR_N_OE_N(PERR_N_OE_N), .SERR_N_O(SERR_N_O), .SERR_N_OE_N(SERR_N_OE_N),
   .CMD_REG(CMD_REG), .CB_ADDR_PERR(CB_ADDR_PERR), .INIT_START(INIT_START),
   .INIT_BUSY(INIT_BUSY), .INIT_DONE(INIT_DONE), .INIT_ABORT(INIT_ABORT),
   .TGT_HIT(TGT_HIT), .TGT_XFER(TGT_XFER));
